/* core/usb3_regs_defs.svh */
// Line numbers, field positions, masks and reset values of the USB 3.0 register bank.
// Assumes one-hot read/write strobe lines, each line one 32-bit word.
`ifndef USB3_REGS_DEFS_SVH
`define USB3_REGS_DEFS_SVH
// Strobe line numbers
`define L_CFG        0
`define L_CMD        1
`define L_IRQ        2
`define L_STAT       3
`define P_CFG        0
`define P_CMD        1
`define P_IRQE       2
`define P_IRQ        3
`define P_DMA        4
`define E_CFG        0
`define E_CTL        1
`define E_CLR        2
`define E_SET        3
`define E_LEN        4
`define E_PLEN       5
`define E_BUF        6
`define E_SEQ        7
`define E_SU0        9
`define E_SU1        10
`define O1_CFG       32
// Link command bits
`define CMD_RXDET    0
`define CMD_RECOVERY_REASON     3
`define CMD_ENTRY    10
`define CMD_EXIT     11
// Control endpoint state and event bits
`define ST_RESULT    0
`define ST_SETUP     1
`define ST_HALT      8
`define ST_DEFER     9
`define ST_WAIT_READY_STATE      10
`define ST_WAIT      14
`define ST_BUSY      15
`define EV_STALL     16
`define EV_SENDSTALL 19
`define EV_RETRY     24
`define EV_INVALID   25
`define EV_NRDY      27
// Implemented-bit masks
`define EP0_CTL_MASK 32'h0B0FC703
`define EP0_LEN_MASK 32'hE01FFFFF
`define PRTE_MASK    24'hFF00FF
// Reset value of every register
`define BANK_RESET   '0
`endif

/* core/usb3_regs_pkg.sv */
// Types of the USB 3.0 register bank: endpoint reply codes and the state record.
// Assumes the constants header is compiled alongside.
package usb3_regs_pkg;
  typedef enum logic [2:0] {
    REPLY_NONE  = 3'h0,
    REPLY_ACK1  = 3'h1,
    REPLY_RETRY = 3'h2,
    REPLY_ACK0  = 3'h3,
    REPLY_STALL = 3'h4,
    REPLY_NRDY  = 3'h5,
    REPLY_ERDY  = 3'h6,
    REPLY_FINAL = 3'h7
  } reply_e;

  typedef struct packed {
    logic [31:0] rd;
    logic        irq;
    logic        pwr_s1;
    logic        pwr_s2;
    logic        link_en;
    logic        pwr_acc;
    logic        scr_off;
    logic [1:0]  ext;
    logic [7:0]  u2t;
    logic        cmd_rxdet;
    logic        cmd_recovery_reason;
    logic        cmd_entry;
    logic        cmd_exit;
    logic [1:0]  pwr_lvl;
    logic        link_irq_en;
    logic [6:0]  reason;
    logic [8:0]  causes;
    logic [6:0]  dev_addr;
    logic        arb_reset;
    logic [23:0] prte_en;
    logic [3:0]  dma_up;
    logic [3:0]  ep_cfg;
    logic [31:0] ep_ctl;
    logic [31:0] ep_len;
    logic [19:0] ep_buf;
    logic [4:0]  ep_seq;
    logic [31:0] setup_lo;
    logic [31:0] setup_hi;
    logic        out1_en;
    reply_e      reply;
    logic        reply_vld;
  } regs_s;
endpackage : usb3_regs_pkg

/* core/usb3_device_control_registers.sv */
// Control and status register bank of a USB 3.0 device link and protocol core.
// Assumes the link, protocol and endpoint engines run on REF_CLK_I and
// present events as one-cycle pulses; only the bus power pin is asynchronous.
// Strobes must be one-hot and last one cycle.
`timescale 1ns/10ps
`include "usb3_regs_defs.svh"
module usb3_device_control_registers (
  // Clock and reset
  input  wire logic                REF_CLK_I,
  input  wire logic                RESETN_I,

  // Register strobes and data
  input  wire logic [15:0]         LINK_REG_RE_I,
  input  wire logic [15:0]         LINK_REG_WE_I,
  input  wire logic [15:0]         PRTE_REG_RE_I,
  input  wire logic [15:0]         PRTE_REG_WE_I,
  input  wire logic [511:0]        XPP_REG_RE_I,
  input  wire logic [511:0]        XPP_REG_WE_I,
  input  wire logic [31:0]         REG_WDATA_I,
  output logic      [31:0]         REG_RDATA_O,

  // Link engine
  input  wire logic [4:0]          LINK_STATE_I,
  input  wire logic [8:0]          LINK_EVENT_I,
  input  wire logic [6:0]          RECOVERY_REASON_I,
  input  wire logic                ADDR_RESET_I,
  input  wire logic                BUS_POWER_ABSENT_I,
  output logic                     LINK_ENABLE_O,
  output logic                     POWER_ACCEPT_O,
  output logic                     SCRAMBLER_OFF_O,
  output logic      [7:0]          U1_TO_U2_TIMER_O,
  output logic                     RX_DETECT_CMD_O,
  output logic                     RECOVERY_CMD_O,
  output logic                     POWER_ENTRY_CMD_O,
  output logic                     POWER_EXIT_CMD_O,
  output logic      [1:0]          POWER_LEVEL_O,

  // Protocol layer
  input  wire logic [23:0]         EP_IRQ_REQ_I,
  output logic      [6:0]          DEVICE_ADDR_O,
  output logic                     ARBITER_RESET_O,
  output logic      [3:0]          DMA_UPPER_O,

  // Control endpoint engine
  input  wire logic                SETUP_RX_I,
  input  wire logic                SETUP_ERROR_I,
  input  wire logic [63:0]         SETUP_DATA_I,
  input  wire logic [31:0]         EP0_HW_SET_I,
  input  wire logic [20:0]         EP0_ACTUAL_LEN_I,
  output logic      [3:0]          EP0_CONFIG_O,
  output logic      [31:0]         EP0_LENGTH_O,
  output logic      [19:0]         EP0_BUFFER_O,
  output logic      [4:0]          EP0_SEQUENCE_O,
  output usb3_regs_pkg::reply_e    EP0_REPLY_O,
  output logic                     EP0_REPLY_VALID_O,
  output logic                     OUT1_ENABLE_O,

  // Interrupt and pins
  output logic                     IRQ_O,
  output logic      [1:0]          EXT_CTL_O
);
  import usb3_regs_pkg::*;

  // Bank state and its next value
  regs_s       s;
  regs_s       n;
  logic [1:0]  rst_q;
  logic        rst_n;
  logic [31:0] wd;
  logic [31:0] rd;
  logic [23:0] pend;
  logic [10:0] gone;
  logic        go_ok;

  // Reset release through two flops so every flop leaves reset on one edge
  // The raw pin only clears; it never releases
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // Outputs straight from the state record
  // No gate in front of any output
  assign REG_RDATA_O       = s.rd;
  assign IRQ_O             = s.irq;
  assign EXT_CTL_O         = s.ext;
  assign LINK_ENABLE_O     = s.link_en;
  assign POWER_ACCEPT_O    = s.pwr_acc;
  assign SCRAMBLER_OFF_O   = s.scr_off;
  assign U1_TO_U2_TIMER_O  = s.u2t;
  assign RX_DETECT_CMD_O   = s.cmd_rxdet;
  assign RECOVERY_CMD_O    = s.cmd_recovery_reason;
  assign POWER_ENTRY_CMD_O = s.cmd_entry;
  assign POWER_EXIT_CMD_O  = s.cmd_exit;
  assign POWER_LEVEL_O     = s.pwr_lvl;
  assign DEVICE_ADDR_O     = s.dev_addr;
  assign ARBITER_RESET_O   = s.arb_reset;
  assign DMA_UPPER_O       = s.dma_up;
  assign EP0_CONFIG_O      = s.ep_cfg;
  assign EP0_LENGTH_O      = s.ep_len;
  assign EP0_BUFFER_O      = s.ep_buf;
  assign EP0_SEQUENCE_O    = s.ep_seq;
  assign EP0_REPLY_O       = s.reply;
  assign EP0_REPLY_VALID_O = s.reply_vld;
  assign OUT1_ENABLE_O     = s.out1_en;

  assign wd = REG_WDATA_I;

  // Pending sources: control endpoint from its state bits, others from engines
  // Lines 8 to 15 have no source
  assign pend = {EP_IRQ_REQ_I[23:1], |s.ep_ctl[13:0]} & `PRTE_MASK;

  // Read multiplexer; strobes are one-hot so the OR of selected words is exact
  always_comb begin
    rd = 32'h0;
    // Link lines
    if (LINK_REG_RE_I[`L_CFG]) begin
      rd = rd | {16'h0, s.u2t, 2'h0, s.ext, 1'b0, s.scr_off, s.pwr_acc, s.link_en};
    end
    if (LINK_REG_RE_I[`L_IRQ]) begin
      rd = rd | {30'h0, s.link_irq_en, |s.causes};
    end
    if (LINK_REG_RE_I[`L_STAT]) begin
      rd = rd | {s.pwr_s2, (s.dev_addr == 7'h0), 1'b0, LINK_STATE_I,
                 8'h0, s.causes, s.reason};
    end

    // Protocol lines
    if (PRTE_REG_RE_I[`P_CFG]) begin
      rd = rd | {25'h0, s.dev_addr};
    end
    if (PRTE_REG_RE_I[`P_IRQE]) begin
      rd = rd | {8'h0, s.prte_en};
    end
    if (PRTE_REG_RE_I[`P_IRQ]) begin
      rd = rd | {8'h0, pend};
    end
    if (PRTE_REG_RE_I[`P_DMA]) begin
      rd = rd | {s.dma_up, 28'h0};
    end

    // Control endpoint lines
    if (XPP_REG_RE_I[`E_CFG]) begin
      rd = rd | {28'h0, s.ep_cfg};
    end
    // Busy hides itself while any of bits 0 to 13 is up; the wait bit (14) does not hide it
    if (XPP_REG_RE_I[`E_CTL]) begin
      rd = rd | {s.ep_ctl[31:16], s.ep_ctl[`ST_BUSY] & ~|s.ep_ctl[13:0],
                 s.ep_ctl[14:0]};
    end
    if (XPP_REG_RE_I[`E_LEN]) begin
      rd = rd | s.ep_len;
    end

    // Length flags 31 and 30 copy the length word; bit 29 reads zero
    if (XPP_REG_RE_I[`E_PLEN]) begin
      rd = rd | {s.ep_len[31:30], 9'h0, EP0_ACTUAL_LEN_I};
    end
    if (XPP_REG_RE_I[`E_BUF]) begin
      rd = rd | {4'h0, s.ep_buf, 8'h0};
    end
    if (XPP_REG_RE_I[`E_SEQ]) begin
      rd = rd | {27'h0, s.ep_seq};
    end
    if (XPP_REG_RE_I[`E_SU0]) begin
      rd = rd | s.setup_lo;
    end
    if (XPP_REG_RE_I[`E_SU1]) begin
      rd = rd | s.setup_hi;
    end

    // OUT endpoint 1 enable only
    if (XPP_REG_RE_I[`O1_CFG]) begin
      rd = rd | {31'h0, s.out1_en};
    end
  end

  // Next-state logic: software effects first, hardware sets last so they win
  always_comb begin
    n = s;
    gone = 11'h0;
    go_ok = s.link_en;
    n.rd = rd;
    // Two-flop sync; only flop two is read
    n.pwr_s1 = BUS_POWER_ABSENT_I;
    n.pwr_s2 = s.pwr_s1;
    // Pulses drop every cycle
    n.cmd_rxdet = 1'b0;
    n.cmd_recovery_reason = 1'b0;
    n.cmd_entry = 1'b0;
    n.cmd_exit = 1'b0;
    n.arb_reset = 1'b0;
    n.reply = REPLY_NONE;
    n.reply_vld = 1'b0;

    // Link configuration
    // Bits 3, 6 and 7 are dropped
    if (LINK_REG_WE_I[`L_CFG]) begin
      n.link_en = wd[0];
      n.pwr_acc = wd[1];
      n.scr_off = wd[2];
      n.ext = wd[5:4];
      n.u2t = wd[15:8];
    end

    // Commands decode each bit; software keeps them one-hot. Without the
    // bus enable no transition is requested at all, so only a drop to
    // SS_Disable (made by the link engine itself) can happen.
    if (LINK_REG_WE_I[`L_CMD]) begin
      n.cmd_rxdet = wd[`CMD_RXDET] & go_ok;
      n.cmd_recovery_reason = wd[`CMD_RECOVERY_REASON] & go_ok;
      n.cmd_entry = wd[`CMD_ENTRY] & go_ok & (wd[9:8] != 2'h0);
      n.cmd_exit = wd[`CMD_EXIT] & go_ok;
      if (wd[`CMD_ENTRY]) begin
        n.pwr_lvl = wd[9:8];
      end
    end

    // Pending is derived, not stored
    if (LINK_REG_WE_I[`L_IRQ]) begin
      n.link_irq_en = wd[1];
    end

    // Causes: write one clears, a same-cycle event still sets
    if (LINK_REG_WE_I[`L_STAT]) begin
      n.causes = s.causes & ~wd[15:7];
    end
    // Reason kept while cause bit 0 (status bit 7) is up
    if (LINK_EVENT_I[0] && !n.causes[0]) begin
      n.reason = RECOVERY_REASON_I;
    end
    n.causes = n.causes | LINK_EVENT_I;

    // Protocol layer
    if (PRTE_REG_WE_I[`P_CFG]) begin
      n.dev_addr = wd[6:0];
    end
    // Engine clear beats a software write
    if (ADDR_RESET_I) begin
      n.dev_addr = 7'h0;
    end

    // A pulse, not a stored bit
    if (PRTE_REG_WE_I[`P_CMD]) begin
      n.arb_reset = wd[0];
    end

    // Sourceless bits stay masked
    if (PRTE_REG_WE_I[`P_IRQE]) begin
      n.prte_en = wd[23:0] & `PRTE_MASK;
    end
    if (PRTE_REG_WE_I[`P_DMA]) begin
      n.dma_up = wd[31:28];
    end

    // Control endpoint plain registers
    if (XPP_REG_WE_I[`E_CFG]) begin
      n.ep_cfg = wd[3:0];
    end

    // Only documented length fields
    if (XPP_REG_WE_I[`E_LEN]) begin
      n.ep_len = wd & `EP0_LEN_MASK;
    end
    if (XPP_REG_WE_I[`E_BUF]) begin
      n.ep_buf = wd[27:8];
    end
    if (XPP_REG_WE_I[`E_SEQ]) begin
      n.ep_seq = wd[4:0];
    end
    if (XPP_REG_WE_I[`E_SU0]) begin
      n.setup_lo = wd;
    end
    if (XPP_REG_WE_I[`E_SU1]) begin
      n.setup_hi = wd;
    end

    // OUT endpoint 1 enable only
    if (XPP_REG_WE_I[`O1_CFG]) begin
      n.out1_en = wd[0];
    end

    // Control register: direct, clear alias and set alias
    if (XPP_REG_WE_I[`E_CTL]) begin
      n.ep_ctl = wd & `EP0_CTL_MASK;
    end
    if (XPP_REG_WE_I[`E_CLR]) begin
      n.ep_ctl = n.ep_ctl & ~wd;
    end
    // Masked so holes stay zero
    if (XPP_REG_WE_I[`E_SET]) begin
      n.ep_ctl = n.ep_ctl | (wd & `EP0_CTL_MASK);
    end
    // Dropping busy while awaiting a packet returns to idle
    if (s.ep_ctl[`ST_WAIT] && s.ep_ctl[`ST_BUSY] && !n.ep_ctl[`ST_BUSY]) begin
      n.ep_ctl[`ST_WAIT] = 1'b0;
    end

    // Automatic exits stand in for the software clear
    if (s.ep_cfg[1]) begin
      n.ep_ctl[`ST_SETUP] = 1'b0;
    end
    if (s.ep_cfg[2]) begin
      n.ep_ctl[`ST_RESULT] = 1'b0;
    end
    if (s.ep_cfg[3] && s.ep_ctl[`ST_HALT]) begin
      n.ep_ctl[`ST_HALT] = 1'b0;
      n.ep_ctl[`EV_SENDSTALL] = 1'b1;
    end

    // One reply per cycle; if several states drop together only the first of
    // setup, result, halt, defer/wait-ready is answered, so software should clear one at a time
    gone = s.ep_ctl[10:0] & ~n.ep_ctl[10:0];
    if (gone[`ST_SETUP]) begin
      n.reply_vld = 1'b1;
      // Disabled beats a receive error
      if (s.ep_ctl[`EV_INVALID]) begin
        n.reply = REPLY_ACK0;
      end else if (s.ep_ctl[`EV_RETRY]) begin
        n.reply = REPLY_RETRY;
      end else begin
        n.reply = REPLY_ACK1;
      end
    end else if (gone[`ST_RESULT]) begin
      n.reply_vld = 1'b1;
      // Stall event first, then the enable
      if (s.ep_ctl[`EV_STALL]) begin
        n.reply = REPLY_STALL;
      end else if (!s.ep_cfg[0]) begin
        n.reply = REPLY_NRDY;
        n.ep_ctl[`EV_NRDY] = 1'b1;
      end else begin
        n.reply = REPLY_FINAL;
      end
    end else if (gone[`ST_HALT]) begin
      n.reply_vld = 1'b1;
      n.reply = REPLY_STALL;
    end else if (gone[`ST_DEFER] || gone[`ST_WAIT_READY_STATE]) begin
      n.reply_vld = 1'b1;
      n.reply = REPLY_ERDY;
    end

    // Hardware sets win over any clear in the same cycle
    n.ep_ctl = n.ep_ctl | (EP0_HW_SET_I & `EP0_CTL_MASK);
    // Captured even while disabled
    if (SETUP_RX_I) begin
      n.setup_lo = SETUP_DATA_I[31:0];
      n.setup_hi = SETUP_DATA_I[63:32];
      n.ep_ctl[`ST_SETUP] = 1'b1;
      n.ep_ctl[`EV_RETRY] = n.ep_ctl[`EV_RETRY] | SETUP_ERROR_I;
      n.ep_ctl[`EV_INVALID] = n.ep_ctl[`EV_INVALID] | ~s.ep_cfg[0];
    end

    // Level interrupt from the settled register state and the raw EP_IRQ_REQ_I lines
    // Lags a link event by two edges, an EP_IRQ_REQ_I line by one
    n.irq = (s.link_irq_en & |s.causes) | |(pend & s.prte_en);
  end

  // The whole bank in one register
  // Constants only in the reset branch
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      s <= `BANK_RESET;
    end else begin
      s <= n;
    end
  end

endmodule : usb3_device_control_registers

/* bench/usb3_host_model.sv */
// Host processor model: one-hot register strobes and write data for the bank.
// Assumes the bench calls access() and read data arrives one cycle on.
`timescale 1ns/10ps
module usb3_host_model (
  // Clock
  input  wire logic         clk_i,
  // Strobes: link, protocol, endpoint lines
  output logic      [15:0]  lre_o,
  output logic      [15:0]  lwe_o,
  output logic      [15:0]  pre_o,
  output logic      [15:0]  pwe_o,
  output logic      [511:0] xre_o,
  output logic      [511:0] xwe_o,
  // Data
  output logic      [31:0]  wd_o,
  input  wire logic [31:0]  rd_i
);
  logic [543:0] re = '0;
  logic [543:0] we = '0;
  // One flat vector so a line index picks any strobe
  assign {xre_o, pre_o, lre_o} = re;
  assign {xwe_o, pwe_o, lwe_o} = we;
  initial wd_o = '0;
  // One strobe for one cycle; released data is inverted so stale data never matches
  task automatic access(input int idx, input logic wr, input logic [31:0] d,
                        output logic [31:0] q);
    @(negedge clk_i);
    wd_o = d;
    if (wr) we[idx] = 1'b1;
    else re[idx] = 1'b1;
    @(negedge clk_i);
    q = rd_i;
    re = '0;
    we = '0;
    wd_o = ~d;
  endtask : access
endmodule : usb3_host_model

/* bench/usb3_regs_props.sv */
// Assertion checker for the USB 3.0 register bank, on top-level ports only.
// Assumes one clock domain and strobes that last one cycle.
`timescale 1ns/10ps
module usb3_regs_props (
  // Clock and reset
  input wire logic         REF_CLK_I,
  input wire logic         RESETN_I,
  // Register bus
  input wire logic [15:0]  LINK_REG_RE_I,
  input wire logic [15:0]  LINK_REG_WE_I,
  input wire logic [15:0]  PRTE_REG_RE_I,
  input wire logic [15:0]  PRTE_REG_WE_I,
  input wire logic [511:0] XPP_REG_RE_I,
  input wire logic [31:0]  REG_WDATA_I,
  input wire logic [31:0]  REG_RDATA_O,
  // Watched pins
  input wire logic         ADDR_RESET_I,
  input wire logic         LINK_ENABLE_O,
  input wire logic         POWER_ACCEPT_O,
  input wire logic         SCRAMBLER_OFF_O,
  input wire logic [7:0]   U1_TO_U2_TIMER_O,
  input wire logic         RX_DETECT_CMD_O,
  input wire logic         RECOVERY_CMD_O,
  input wire logic         POWER_ENTRY_CMD_O,
  input wire logic [6:0]   DEVICE_ADDR_O,
  input wire logic [3:0]   DMA_UPPER_O,
  input wire logic         EP0_REPLY_VALID_O,
  input wire logic [1:0]   EXT_CTL_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RESETN_I);
  // Configuration levels follow the write one cycle on
  chk_cfg_levels: assert property (
    $past(LINK_REG_WE_I[0]) |-> {SCRAMBLER_OFF_O, POWER_ACCEPT_O, LINK_ENABLE_O}
      == $past(REG_WDATA_I[2:0])) else $error("link config levels wrong");
  chk_timer_field: assert property (
    $past(LINK_REG_WE_I[0]) |-> U1_TO_U2_TIMER_O == $past(REG_WDATA_I[15:8]))
    else $error("inactivity timer wrong");
  chk_ext_pins: assert property (
    $past(LINK_REG_WE_I[0]) && !LINK_REG_WE_I[0] |-> ##1 EXT_CTL_O == $past(REG_WDATA_I[5:4], 2))
    else $error("external control pins wrong");
  // Commands pulse only while the link is enabled
  chk_rxdet_cmd: assert property (
    RX_DETECT_CMD_O == $past(LINK_REG_WE_I[1] & REG_WDATA_I[0] & LINK_ENABLE_O))
    else $error("receiver detect pulse wrong");
  chk_recov_cmd: assert property (
    RECOVERY_CMD_O == $past(LINK_REG_WE_I[1] & REG_WDATA_I[3] & LINK_ENABLE_O))
    else $error("recovery pulse wrong");
  chk_entry_cmd: assert property (
    POWER_ENTRY_CMD_O == $past(LINK_REG_WE_I[1] & REG_WDATA_I[10] & LINK_ENABLE_O
      & (|REG_WDATA_I[9:8]))) else $error("power entry pulse wrong");
  chk_read_idle: assert property (
    !$past(|{LINK_REG_RE_I, PRTE_REG_RE_I, XPP_REG_RE_I}) |-> REG_RDATA_O == '0)
    else $error("read data without a read strobe");
  chk_addr_clear: assert property (
    $past(ADDR_RESET_I & !PRTE_REG_WE_I[0]) |-> DEVICE_ADDR_O == '0)
    else $error("device address not cleared");
  chk_dma_upper: assert property (
    $past(PRTE_REG_WE_I[4]) |-> DMA_UPPER_O == $past(REG_WDATA_I[31:28]))
    else $error("dma upper bits wrong");
  // Main scenarios reached
  cov_rxdet: cover property (RX_DETECT_CMD_O);
  cov_reply: cover property (EP0_REPLY_VALID_O);
  cov_addr: cover property (ADDR_RESET_I);
endmodule : usb3_regs_props

bind usb3_device_control_registers usb3_regs_props chk_u (
  .REF_CLK_I, .RESETN_I, .LINK_REG_RE_I, .LINK_REG_WE_I, .PRTE_REG_RE_I, .PRTE_REG_WE_I,
  .XPP_REG_RE_I, .REG_WDATA_I, .REG_RDATA_O, .ADDR_RESET_I, .LINK_ENABLE_O, .POWER_ACCEPT_O,
  .SCRAMBLER_OFF_O, .U1_TO_U2_TIMER_O, .RX_DETECT_CMD_O, .RECOVERY_CMD_O, .POWER_ENTRY_CMD_O,
  .DEVICE_ADDR_O, .DMA_UPPER_O, .EP0_REPLY_VALID_O, .EXT_CTL_O);

/* bench/usb3_device_control_registers_test.sv */
// Self-checking bench for the USB 3.0 register bank and its engine pins.
// Assumes the host model owns the strobes; engine inputs are driven here.
`timescale 1ns/10ps
`include "usb3_regs_defs.svh"
module usb3_device_control_registers_test;
  import usb3_regs_pkg::*;
  localparam int LP = 16; // Protocol lines follow the link lines
  localparam int LX = 32;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] lre, lwe, pre, pwe;
  logic [511:0] xre, xwe;
  logic [31:0] wd, rdata, elen;
  logic [8:0] levt = '0;
  logic [6:0] reason = '0, addr;
  logic [4:0] lstate = '0, eseq;
  logic arst = 1'b0, vbus = 1'b0, srx = 1'b0, serr = 1'b0;
  logic [63:0] sdata = '0;
  logic [23:0] epirq = '0;
  logic [31:0] hwset = '0;
  logic [20:0] alen = '0;
  logic [19:0] ebuf;
  logic [7:0] u2t;
  logic [3:0] dma, ecfg;
  logic [1:0] plvl, ext;
  logic en, acc, scr, c_rx, c_rc, c_en, c_ex, arb, out1, irq, rvld;
  reply_e rcode;
  int miscompares = 0;
  int checks_done = 0;
  // Core clock, 100 MHz
  always #5 clk = ~clk;
  usb3_device_control_registers dut_u (
    .REF_CLK_I(clk), .RESETN_I(rst_n), .LINK_REG_RE_I(lre), .LINK_REG_WE_I(lwe),
    .PRTE_REG_RE_I(pre), .PRTE_REG_WE_I(pwe), .XPP_REG_RE_I(xre), .XPP_REG_WE_I(xwe),
    .REG_WDATA_I(wd), .REG_RDATA_O(rdata), .LINK_STATE_I(lstate), .LINK_EVENT_I(levt),
    .RECOVERY_REASON_I(reason), .ADDR_RESET_I(arst), .BUS_POWER_ABSENT_I(vbus),
    .LINK_ENABLE_O(en), .POWER_ACCEPT_O(acc), .SCRAMBLER_OFF_O(scr), .U1_TO_U2_TIMER_O(u2t),
    .RX_DETECT_CMD_O(c_rx), .RECOVERY_CMD_O(c_rc), .POWER_ENTRY_CMD_O(c_en),
    .POWER_EXIT_CMD_O(c_ex), .POWER_LEVEL_O(plvl), .EP_IRQ_REQ_I(epirq),
    .DEVICE_ADDR_O(addr), .ARBITER_RESET_O(arb), .DMA_UPPER_O(dma), .SETUP_RX_I(srx),
    .SETUP_ERROR_I(serr), .SETUP_DATA_I(sdata), .EP0_HW_SET_I(hwset),
    .EP0_ACTUAL_LEN_I(alen), .EP0_CONFIG_O(ecfg), .EP0_LENGTH_O(elen), .EP0_BUFFER_O(ebuf),
    .EP0_SEQUENCE_O(eseq), .EP0_REPLY_O(rcode), .EP0_REPLY_VALID_O(rvld),
    .OUT1_ENABLE_O(out1), .IRQ_O(irq), .EXT_CTL_O(ext));
  usb3_host_model host_u (.clk_i(clk), .lre_o(lre), .lwe_o(lwe), .pre_o(pre), .pwe_o(pwe),
    .xre_o(xre), .xwe_o(xwe), .wd_o(wd), .rd_i(rdata));
  // Verdict and end of run
  task automatic summarize();
    if (miscompares == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  task automatic wr(input int idx, input logic [31:0] d);
    logic [31:0] x;
    host_u.access(idx, 1'b1, d, x);
  endtask : wr
  task automatic rd(input int idx, input logic [31:0] m, input logic [31:0] e, input string w);
    logic [31:0] x;
    host_u.access(idx, 1'b0, 32'h0, x);
    check(x & m, e, w);
  endtask : rd
  // Bounded wait: a missing reply ends the run rather than hanging it
  task automatic wait_reply(input reply_e e);
    int i;
    for (i = 0; i < 4 && rvld !== 1'b1; i++) @(negedge clk);
    if (rvld !== 1'b1) begin
      miscompares++;
      $display("MISMATCH %0t no endpoint reply", $time);
      summarize();
    end
    check({29'h0, rcode}, {29'h0, e}, "reply code");
  endtask : wait_reply
  task automatic pulse_evt(input logic [8:0] e, input logic [6:0] r);
    @(negedge clk);
    levt = e;
    reason = r;
    @(negedge clk);
    levt = '0;
  endtask : pulse_evt
  task automatic pulse_setup(input logic err);
    @(negedge clk);
    srx = 1'b1;
    serr = err;
    @(negedge clk);
    srx = 1'b0;
  endtask : pulse_setup
  task automatic s_link_config();
    wr(`L_CFG, 32'hFFFF_FFFF);
    rd(`L_CFG, '1, 32'h0000_FF37, "link cfg readback");
    wr(`L_CFG, 32'h0000_A516);
    check({16'h0, u2t, 2'b0, ext, 1'b0, scr, acc, en}, 32'hA516, "cfg pins");
  endtask : s_link_config
  task automatic s_commands();
    logic [31:0] cmds [4] = '{32'h1, 32'h8, 32'h600, 32'h800};
    foreach (cmds[i]) begin
      wr(`L_CMD, cmds[i]);
      check({28'h0, c_rx, c_rc, c_en, c_ex}, 32'h0, "command while disabled");
    end
    wr(`L_CFG, 32'h1);
    foreach (cmds[i]) begin
      wr(`L_CMD, cmds[i]);
      check({28'h0, c_rx, c_rc, c_en, c_ex}, 32'h8 >> i, "command pulse");
    end
    check({30'h0, plvl}, 32'h2, "power level");
    wr(`L_CMD, 32'h400);
    check({31'h0, c_en}, 32'h0, "entry with no level");
  endtask : s_commands
  task automatic s_link_irq();
    lstate = 5'h11;
    vbus = 1'b1;
    wr(`L_IRQ, 32'h2);
    pulse_evt(9'h001, 7'h5A);
    pulse_evt(9'h001, 7'h33);
    check({31'h0, irq}, 32'h1, "link irq out");
    rd(`L_STAT, '1, 32'hD100_00DA, "link status");
    rd(`L_IRQ, '1, 32'h3, "link irq reg");
    wr(`L_STAT, 32'h80);
    rd(`L_STAT, 32'h0000_FF80, 32'h0, "cause cleared");
    check({31'h0, irq}, 32'h0, "irq dropped");
    wr(`L_IRQ, 32'h0);
    pulse_evt(9'h100, 7'h0);
    rd(`L_IRQ, '1, 32'h1, "pending without enable");
    check({31'h0, irq}, 32'h0, "masked irq");
    wr(`L_STAT, 32'h8000);
  endtask : s_link_irq
  task automatic s_protocol();
    wr(LP + `P_CFG, 32'hFFFF_FFD5);
    rd(LP + `P_CFG, '1, 32'h55, "device address");
    rd(`L_STAT, 32'h4000_0000, 32'h0, "address set flag");
    @(negedge clk) arst = 1'b1;
    @(negedge clk) arst = 1'b0;
    check({25'h0, addr}, 32'h0, "address cleared");
    rd(`L_STAT, 32'h4000_0000, 32'h4000_0000, "address unset flag");
    wr(LP + `P_DMA, 32'hFFFF_FFFF);
    rd(LP + `P_DMA, '1, 32'hF000_0000, "dma upper");
    check({28'h0, dma}, 32'hF, "dma pins");
    wr(LP + `P_CMD, 32'h1);
    check({31'h0, arb}, 32'h1, "arbiter reset pulse");
    wr(LP + `P_IRQE, 32'hFFFF_FFFF);
    rd(LP + `P_IRQE, '1, 32'h00FF_00FF, "irq enables");
    epirq = 24'h01_0000;
    rd(LP + `P_IRQ, '1, 32'h0001_0000, "protocol pending");
    @(negedge clk);
    check({31'h0, irq}, 32'h1, "endpoint irq out");
    wr(LP + `P_IRQE, 32'h00FE_FFFF);
    rd(7, '1, 32'h0, "unmapped line");
    check({31'h0, irq}, 32'h0, "disabled endpoint irq");
    epirq = '0;
    wr(LP + `P_IRQE, 32'h1);
  endtask : s_protocol
  task automatic s_setup();
    reply_e codes [3] = '{REPLY_ACK0, REPLY_RETRY, REPLY_ACK1};
    for (int i = 0; i < 3; i++) begin
      wr(LX + `E_CFG, {31'h0, i != 0});
      wr(LX + `E_CLR, 32'hFFFF_FFFF);
      sdata = {32'h0123_4567 + i, 32'h89AB_CDEF};
      pulse_setup(i == 1);
      rd(LX + `E_CTL, 32'h0300_0002, {6'h0, i == 0, i == 1, 24'h2}, "setup state");
      rd(LX + `E_SU0, '1, 32'h89AB_CDEF, "setup low");
      rd(LX + `E_SU1, '1, 32'h0123_4567 + i, "setup high");
      check({31'h0, irq}, 32'h1, "setup irq");
      wr(LX + `E_CLR, 32'h2);
      wait_reply(codes[i]);
    end
    wr(LX + `E_CFG, 32'h3);
    pulse_setup(1'b0);
    wait_reply(REPLY_ACK1);
  endtask : s_setup
  task automatic s_states();
    logic [31:0] bits [5] = '{32'h1, 32'h1, 32'h100, 32'h200, 32'h400};
    reply_e codes [5] = '{REPLY_FINAL, REPLY_NRDY, REPLY_STALL, REPLY_ERDY, REPLY_ERDY};
    foreach (bits[i]) begin
      wr(LX + `E_CFG, {31'h0, i != 1});
      wr(LX + `E_SET, bits[i]);
      rd(LX + `E_CTL, 32'h0000_3FFF, bits[i], "state set");
      wr(LX + `E_CLR, bits[i]);
      wait_reply(codes[i]);
    end
    rd(LX + `E_CTL, 32'h0800_0000, 32'h0800_0000, "nrdy event");
    wr(LX + `E_SET, 32'h0001_0001);
    wr(LX + `E_CLR, 32'h1);
    wait_reply(REPLY_STALL);
    wr(LX + `E_CFG, 32'h9);
    wr(LX + `E_SET, 32'h100);
    wait_reply(REPLY_STALL);
    wr(LX + `E_SET, 32'hC000);
    rd(LX + `E_CTL, 32'h0000_C000, 32'h0000_C000, "busy waiting");
    wr(LX + `E_CLR, 32'h8000);
    rd(LX + `E_CTL, 32'h0000_C000, 32'h0, "back to idle");
  endtask : s_states
  // An engine event and a software clear in one cycle: the event must stay
  task automatic s_hw_event();
    fork
      wr(LX + `E_CLR, 32'h0004_0000);
      begin
        @(negedge clk) hwset = 32'h0004_0000;
        @(negedge clk) hwset = '0;
      end
    join
    rd(LX + `E_CTL, 32'h0004_0000, 32'h0004_0000, "event beats clear");
    wr(LX + `E_CLR, 32'h0004_0000);
    rd(LX + `E_CTL, 32'h0004_0000, 32'h0, "event cleared");
  endtask : s_hw_event
  task automatic s_regs();
    int lines [5] = '{`E_LEN, `E_BUF, `E_SEQ, `O1_CFG, `E_CFG};
    logic [31:0] exp [5] = '{`EP0_LEN_MASK, 32'h0FFF_FF00, 32'h1F, 32'h1, 32'hF};
    foreach (lines[i]) begin
      wr(LX + lines[i], 32'hFFFF_FFFF);
      rd(LX + lines[i], '1, exp[i], "endpoint register");
    end
    check(elen, `EP0_LEN_MASK, "length pins");
    check({ebuf, 7'h0, eseq}, 32'hFFFF_F01F, "buffer and sequence pins");
    check({27'h0, out1, ecfg}, 32'h1F, "config pins");
    alen = 21'h1A_BCDE;
    rd(LX + `E_PLEN, 32'h001F_FFFF, 32'h001A_BCDE, "actual length");
    rd(LX + 8, '1, 32'h0, "unmapped endpoint line");
  endtask : s_regs
  // Reset for 20 cycles, then the scenarios in turn
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    s_link_config();
    s_commands();
    s_link_irq();
    s_protocol();
    s_setup();
    s_states();
    s_hw_event();
    s_regs();
    summarize();
  end
endmodule : usb3_device_control_registers_test
